//--- hdl/apms_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module apms_sequencer
  import apms_pkg::*;
(
  // Clocks and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sclk,
  // Serial pins
  input wire logic csN,
  input wire logic din,
  output logic dout,
  output logic doutOe,
  // Converter core
  input wire logic [RES_W-1:0] convResult,
  output logic trackHold,
  // Power status
  output apms_pstate_t powerState,
  output apms_mode_t powerMode,
  output logic refDisable,
  output logic convValid
);

  // ----------------------------------------------------------
  // Serial clock domain
  // ----------------------------------------------------------
  // Frame reset: the frame's own signal ends link logic, since
  // the serial clock may stop as soon as chip select rises.
  logic frameRst;
  logic [CNT_W-1:0] riseCnt_r;
  logic [CNT_W-1:0] riseNum;
  logic [CTRL_W-1:0] shReg_r;
  logic [CTRL_W-1:0] ctrlReg_r;
  logic [CTRL_W-1:0] ctrlNew;
  logic ctrlTgl_r;
  logic downTgl_r;
  logic sampTgl_r;
  logic wakeTgl_r;
  logic fallSeen_r;
  logic wakeNow;
  logic [RES_W-1:0] resWord_r;
  logic [WORD_W-1:0] outWord;
  logic [3:0] outIdx;
  logic doutBit_r;
  logic trackHold_r;

  assign frameRst = csN | ~reset_n; // RL16
  // Count of the rising edge now arriving, wrapping for back-to-back
  // conversions while chip select stays low
  assign riseNum = (riseCnt_r == CNT_FRAME) ? CNT_ONE : riseCnt_r + CNT_ONE; // RL15
  assign ctrlNew = {shReg_r[CTRL_W-2:0], din};

  always_ff @(posedge sclk or posedge frameRst) begin
    if (frameRst) begin
      riseCnt_r <= '0;
    end else begin
      riseCnt_r <= riseNum; // RL15
    end
  end

  always_ff @(posedge sclk or posedge frameRst) begin
    if (frameRst) begin
      shReg_r <= '0;
    end else if (riseNum <= CNT_CTRL_LAST) begin
      shReg_r <= ctrlNew; // RL13
    end
  end

  // Control word survives frames; only reset clears it
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlReg_r <= CTRL_RST; // RL6
    end else if (riseNum == CNT_CTRL_LAST) begin
      ctrlReg_r <= ctrlNew; // RL13 RL18
    end
  end

  // Event toggles toward the reference domain
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlTgl_r <= 1'b0;
      downTgl_r <= 1'b0;
      sampTgl_r <= 1'b0;
    end else begin
      if (riseNum == CNT_CTRL_LAST) begin
        ctrlTgl_r <= ~ctrlTgl_r;
      end
      // Mode loaded at edge eight of this frame decides here
      if (riseNum == CNT_FRAME && apms_is_auto(apms_mode_t'(ctrlReg_r[PM_HI_POS:PM_LO_POS]))) begin
        downTgl_r <= ~downTgl_r; // RL2 RL23 RL17 RL19
      end
      if (riseNum == CNT_SAMPLE) begin
        sampTgl_r <= ~sampTgl_r; // RL10
      end
    end
  end

  // Core result is taken at the hold edge; the core owns its timing
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      resWord_r <= '0;
    end else if (riseNum == CNT_SAMPLE) begin
      resWord_r <= convResult; // RL10
    end
  end

  // Track during the first 1.5 clocks, hold for the next 14, up to the sixteenth rising edge
  always_ff @(posedge sclk or posedge frameRst) begin
    if (frameRst) begin
      trackHold_r <= 1'b0;
    end else if (riseNum == CNT_SAMPLE) begin
      trackHold_r <= 1'b1; // RL20
    end else if (riseNum == CNT_FRAME) begin
      trackHold_r <= 1'b0; // RL20
    end
  end

  assign wakeNow = ~fallSeen_r | (riseCnt_r == CNT_FRAME);

  always_ff @(negedge sclk or posedge frameRst) begin
    if (frameRst) begin
      fallSeen_r <= 1'b0;
    end else begin
      fallSeen_r <= 1'b1;
    end
  end

  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      wakeTgl_r <= 1'b0;
    end else if (wakeNow && !csN) begin
      wakeTgl_r <= ~wakeTgl_r; // RL3
    end
  end

  // Each bit leaves on a falling edge, valid at the next rising one
  assign outWord = {{LEAD_ZEROS{1'b0}}, resWord_r};
  assign outIdx = OUT_TOP - riseCnt_r[3:0];

  always_ff @(negedge sclk or posedge frameRst) begin
    if (frameRst) begin
      doutBit_r <= 1'b0;
    end else begin
      doutBit_r <= outWord[outIdx]; // RL22
    end
  end

  // ----------------------------------------------------------
  // Crossing into the reference domain
  // ----------------------------------------------------------
  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncOut;
  logic [SYNC_W-1:0] syncPrev_r;
  logic csLow;
  logic csRise;
  logic wakeEv;
  logic downEv;
  logic ctrlEv;
  logic sampEv;

  assign syncIn = {csN, wakeTgl_r, downTgl_r, ctrlTgl_r, sampTgl_r};

  apms_sync2 #(
    .W(SYNC_W),
    .RST_VAL(SYNC_RST)
  ) uSync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .d(syncIn),
    .q(syncOut)
  );

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncPrev_r <= SYNC_RST;
    end else begin
      syncPrev_r <= syncOut;
    end
  end

  assign csLow = ~syncOut[4];
  assign csRise = syncOut[4] & ~syncPrev_r[4];
  assign wakeEv = syncOut[3] ^ syncPrev_r[3];
  assign downEv = syncOut[2] ^ syncPrev_r[2];
  assign ctrlEv = syncOut[1] ^ syncPrev_r[1];
  assign sampEv = syncOut[0] ^ syncPrev_r[0];

  // ----------------------------------------------------------
  // Mode and reference control
  // ----------------------------------------------------------
  // Control word is stable for at least eight serial clocks after its
  // toggle, far longer than the three-cycle crossing, so it is read here.
  apms_mode_t pmode_r;
  logic refDis_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pmode_r <= MODE_CS; // RL6
      refDis_r <= 1'b0;
    end else if (ctrlEv) begin
      pmode_r <= apms_mode_t'(ctrlReg_r[PM_HI_POS:PM_LO_POS]); // RL1
      refDis_r <= ctrlReg_r[REF_DIS_POS]; // RL21
    end
  end

  // ----------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------
  apms_pstate_t state_r;
  apms_pstate_t state_nxt;
  apms_pstate_t downTarget;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic wakeReq;
  logic pupLoadEn;

  function automatic logic [TMR_W-1:0] pupLoad(input logic fromStby, input logic refOff);
    return (fromStby || refOff) ? PUP_STBY_LOAD : PUP_FULL_LOAD; // RL7 RL8
  endfunction : pupLoad

  assign wakeReq = (pmode_r == MODE_ON) // RL12
                 | ((pmode_r == MODE_CS) & csLow) // RL4
                 | (apms_is_auto(pmode_r) & wakeEv); // RL3
  assign downTarget = (pmode_r == MODE_AUTO_STBY) ? PS_STBY : PS_OFF; // RL17 RL19

  always_comb begin
    state_nxt = state_r;
    tmr_nxt = (tmr_r == '0) ? '0 : tmr_r - 1'b1;
    pupLoadEn = 1'b0;
    unique case (state_r)
      PS_OFF, PS_STBY: begin
        if (wakeReq) begin
          state_nxt = PS_WAKE;
          tmr_nxt = pupLoad(state_r == PS_STBY, refDis_r); // RL7 RL8
          pupLoadEn = 1'b1;
        end
      end
      PS_WAKE, PS_READY: begin
        if (pmode_r == MODE_CS && !csLow) begin
          state_nxt = PS_OFF; // RL4 RL5
        end else if (downEv && apms_is_auto(pmode_r)) begin
          // Next frame's wake may land in the same cycle as this down
          if (wakeEv) begin
            state_nxt = PS_WAKE;
            tmr_nxt = pupLoad(downTarget == PS_STBY, refDis_r);
            pupLoadEn = 1'b1;
          end else begin
            state_nxt = downTarget; // RL2
          end
        end else if (state_r == PS_WAKE && tmr_r == '0) begin
          state_nxt = PS_READY;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= PS_OFF; // RL6
      tmr_r <= '0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // Sample taken while not ready is flagged; set wins over abandon
  logic convValid_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      convValid_r <= 1'b0;
    end else if (sampEv) begin
      convValid_r <= (state_r == PS_READY); // RL24
    end else if (state_r != PS_OFF && state_nxt == PS_OFF) begin
      convValid_r <= 1'b0; // RL5
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign powerState = state_r; // RL24
  assign powerMode = pmode_r;
  assign refDisable = refDis_r;
  assign convValid = convValid_r;
  assign dout = doutBit_r;
  assign doutOe = ~csN;
  assign trackHold = trackHold_r;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  logic [TMR_W:0] wakeLen_r;
  logic wakeShort_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeLen_r <= '0;
      wakeShort_r <= 1'b0;
    end else if (pupLoadEn) begin
      wakeLen_r <= '0;
      wakeShort_r <= (tmr_nxt == PUP_STBY_LOAD);
    end else begin
      wakeLen_r <= wakeLen_r + 1'b1;
    end
  end

  // Two clock domains here, so every property names its own clock
  sequence sReadyEntry;
    state_r == PS_WAKE ##1 state_r == PS_READY;
  endsequence

  sequence sAutoWake;
    apms_is_auto(pmode_r) && wakeEv && state_r == PS_OFF;
  endsequence

  AST_RESET_MODE: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL6
                                   $past(reset_n) == 1'b0 |-> pmode_r == MODE_CS && state_r == PS_OFF)
    else $error("mode or state wrong after reset");

  AST_CS_RISE_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL5
                                    pmode_r == MODE_CS && !csLow && state_r != PS_OFF |=> state_r == PS_OFF)
    else $error("chip select high did not shut down");

  AST_ALWAYS_ON: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL12
                                  pmode_r == MODE_ON && state_r == PS_READY && !ctrlEv |=> state_r == PS_READY)
    else $error("left ready in always-on mode");

  AST_FULL_DELAY: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL7
                                   sReadyEntry ##0 !wakeShort_r |-> $past(wakeLen_r) == PUP_FULL_CYC - 1)
    else $error("full power-up length wrong");

  AST_SHORT_DELAY: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL8
                                    sReadyEntry ##0 wakeShort_r |-> $past(wakeLen_r) == PUP_STBY_CYC - 1)
    else $error("short power-up length wrong");

  AST_AUTO_WAKE: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL3
                                  sAutoWake |=> state_r == PS_WAKE ##1 state_r != PS_OFF)
    else $error("auto mode did not start power-up");

  AST_AUTO_DOWN: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL19
                                  downEv && !wakeEv && pmode_r == MODE_AUTO_STBY && state_r == PS_READY
                                  |=> state_r == PS_STBY)
    else $error("auto-standby did not enter standby");

  AST_VALID_FLAG: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL24
                                   sampEv |=> convValid_r == ($past(state_r) == PS_READY))
    else $error("conversion valid flag wrong");

  AST_CTRL_LOAD: assert property (@(posedge sclk) disable iff (frameRst) // RL13
                                  riseNum == CNT_CTRL_LAST |=> ctrlReg_r == $past(ctrlNew))
    else $error("control word not loaded");

  AST_LEAD_ZEROS: assert property (@(posedge sclk) disable iff (frameRst) // RL22
                                   riseCnt_r >= CNT_ONE && riseCnt_r < 5'h04 |-> doutBit_r == 1'b0)
    else $error("leading zero missing");

endmodule : apms_sequencer

`default_nettype wire

//--- inc/apms_pkg.sv
//------------------------------------------------------------
// Contract
// RL1 - Two control bits select one of four power modes.
// RL2 - Auto modes power down on the sixteenth rising serial clock of a frame.
// RL3 - Auto modes start power-up on the first falling serial clock of a frame.
// RL4 - Default mode: chip select high powers down, low powers up.
// RL5 - Default mode: chip select rising mid-conversion powers down at once, abandoning it.
// RL6 - After supply-on reset the mode field reads zero, chip-select mode.
// RL7 - Power-up from full shutdown takes 5 us.
// RL8 - Power-up takes 1 us from standby or with reference disabled.
// RL9 - Host waits the 5 us power-up before starting conversion in shutdown modes.
// RL10 - Input is sampled on the second rising serial clock of a frame.
// RL11 - Host unable to wait writes always-on, discards first result, converts again.
// RL12 - Always-on mode keeps the device powered regardless of chip select.
// RL13 - First eight data-in bits of each frame load the control register.
// RL14 - Host rewrites always-on mode on every transfer to keep it.
// RL15 - Each conversion and its transfer take sixteen serial clocks in one frame.
// RL16 - After chip select rises the host may start a new frame immediately.
// RL17 - Auto-shutdown mode keeps reference enabled, powers down after each conversion. The code powers down to PS_OFF: 5 us power-up, 1 us if reference off.
// RL18 - Data-in held low loads all zeros, giving read-only default mode.
// RL19 - Auto-standby mode keeps only the reference powered after each conversion.
// RL20 - Acquisition takes 1.5 clocks; conversion takes 14.5 more after sampling.
// RL21 - Control bit five set disables the internal reference, cleared enables it.
// RL22 - Output word: four leading zeros, then twelve result bits, MSB first.
// RL23 - A mode written in a frame governs that frame's power-down decision.
// RL24 - Power state is shown; conversions sampled before ready are flagged invalid.
//------------------------------------------------------------
`default_nettype none

package apms_pkg;

  // ----------------------------------------------------------
  // Timing
  // ----------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int PUP_FULL_NS = 5000;
  localparam int PUP_STBY_NS = 1000;
  localparam int PUP_FULL_CYC = (PUP_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PUP_STBY_CYC = (PUP_STBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] PUP_FULL_LOAD = TMR_W'(PUP_FULL_CYC - 1);
  localparam logic [TMR_W-1:0] PUP_STBY_LOAD = TMR_W'(PUP_STBY_CYC - 1);

  // ----------------------------------------------------------
  // Control word and serial frame
  // ----------------------------------------------------------
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam int PM_LO_POS = 0;
  localparam int PM_HI_POS = 1;
  localparam int REF_DIS_POS = 5;
  localparam int RES_W = 12;
  localparam int WORD_W = 16;
  localparam int LEAD_ZEROS = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_SAMPLE = 5'h02;
  localparam logic [CNT_W-1:0] CNT_CTRL_LAST = 5'h08;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h10;
  localparam logic [3:0] OUT_TOP = 4'hf;

  // Synchroniser lanes: chip select, wake, down, control, sample
  localparam int SYNC_W = 5;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h10;

  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CS = 2'b00,
    MODE_ON = 2'b01,
    MODE_AUTO_OFF = 2'b10,
    MODE_AUTO_STBY = 2'b11
  } apms_mode_t;

  typedef enum logic [1:0] {
    PS_OFF = 2'b00,
    PS_WAKE = 2'b01,
    PS_READY = 2'b11,
    PS_STBY = 2'b10
  } apms_pstate_t;

  function automatic logic apms_is_auto(input apms_mode_t m);
    return m[PM_HI_POS];
  endfunction : apms_is_auto

endpackage : apms_pkg

`default_nettype wire

//--- hdl/apms_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module apms_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : apms_sync2

`default_nettype wire

//--- verification/apms_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module apms_host_model (
  // Serial pins
  output logic csN,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic doutOe,
  // Captured result word
  output logic [15:0] wordOut,
  output logic wordDone
);
  // ----------------------------------------------------------
  // Idle: clock parked high, device deselected
  // ----------------------------------------------------------
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
    wordOut = 16'h0000;
    wordDone = 1'b0;
  end

  // ----------------------------------------------------------
  // One frame; nRise below 16 aborts mid-conversion
  // ----------------------------------------------------------
  task automatic frame(input logic [7:0] ctrl, input int leadNs, input int waitNs, input int nRise);
    logic [15:0] w;
    w = 16'h0000;
    csN = 1'b0;
    #(leadNs);
    for (int k = 0; k < nRise; k++) begin
      sclk = 1'b0;
      // Past the control byte din is junk, so it toggles
      din = (k < 8) ? ctrl[7-k] : ~din;
      #3;
      // Power-up wait before the sampling edge
      if (k == 0) #(waitNs);
      sclk = 1'b1;
      w = {w[14:0], dout & doutOe};
      #3;
    end
    csN = 1'b1;
    din = ~din;
    if (nRise == 16) begin
      wordOut = w;
      wordDone = ~wordDone;
    end
    // Next frame may follow at once
    #2;
  endtask : frame
endmodule : apms_host_model

`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
  import apms_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic csN, sclk, din, dout, doutOe, trackHold, convValid, refDisable, hostDone;
  logic [RES_W-1:0] convResult = 12'h000;
  logic [15:0] hostWord;
  apms_pstate_t powerState;
  apms_mode_t powerMode;
  logic [15:0] expQ[$];
  int nFail = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 84;

  always #4 ref_clk = ~ref_clk;

  apms_sequencer i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .csN(csN), .din(din),
    .dout(dout), .doutOe(doutOe), .convResult(convResult), .trackHold(trackHold),
    .powerState(powerState), .powerMode(powerMode), .refDisable(refDisable), .convValid(convValid));

  apms_host_model i_host (.csN(csN), .sclk(sclk), .din(din), .dout(dout), .doutOe(doutOe),
    .wordOut(hostWord), .wordDone(hostDone));

  // ----------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      results();
    end
  end

  // Words come back in frame order
  // Start after reset so the host's time-zero settling is not taken for a word
  initial begin
    wait (reset_n === 1'b1);
    forever begin
      @(hostDone);
      // Let the captured word settle through the port first
      #1;
      if (expQ.size() == 0)
        check(hostWord, 16'hdead);
      else
        check(hostWord, expQ.pop_front());
    end
  end

  // ----------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------
  task automatic runFrame(input logic [7:0] ctrl, input int leadNs, input int waitNs, input int nRise);
    @(negedge ref_clk);
    convResult = 12'($random(seed));
    if (nRise == 16)
      expQ.push_back({4'h0, convResult});
    i_host.frame(ctrl, leadNs, waitNs, nRise);
  endtask : runFrame

  task automatic waitState(input apms_pstate_t exp, input int maxCyc);
    int n;
    n = 0;
    while (powerState !== exp && n < maxCyc) begin
      @(negedge ref_clk);
      n++;
    end
    check({14'h0, powerState}, {14'h0, exp});
  endtask : waitState

  // Length of the powering-up phase, one cycle of slack for sync
  task automatic measureWake(input int expCyc);
    int n;
    n = 0;
    while (powerState !== PS_WAKE && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    n = 0;
    while (powerState === PS_WAKE && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0, n >= expCyc - 1 && n <= expCyc + 1}, 16'h0001);
  endtask : measureWake

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (8) @(negedge ref_clk);
    check({14'h0, powerState}, {14'h0, PS_OFF});
    check({14'h0, powerMode}, {14'h0, MODE_CS});
    check({14'h0, refDisable, convValid}, 16'h0000);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check({15'h0, doutOe}, 16'h0000);
    // Chip-select mode, host waits out full power-up
    fork
      runFrame(8'h00, 5, 5200, 16);
      measureWake(PUP_FULL_CYC);
    join
    check({15'h0, convValid}, 16'h0001);
    waitState(PS_OFF, 10);
    // Abort before the control byte completes
    runFrame(8'h01, 5, 0, 6);
    waitState(PS_OFF, 10);
    check({14'h0, powerMode}, {14'h0, MODE_CS});
    check({14'h0, trackHold, doutOe}, 16'h0000);
    // Fast host: always-on, discard first, convert again
    runFrame(8'h01, 5, 0, 16);
    check({14'h0, powerMode}, {14'h0, MODE_ON});
    check({15'h0, convValid}, 16'h0000);
    waitState(PS_READY, 700);
    repeat (20) @(negedge ref_clk);
    check({14'h0, powerState}, {14'h0, PS_READY});
    runFrame(8'h01, 5, 0, 16);
    check({15'h0, convValid}, 16'h0001);
    // Auto-standby, written in the frame it governs
    runFrame(8'h03, 5, 0, 16);
    check({14'h0, powerMode}, {14'h0, MODE_AUTO_STBY});
    waitState(PS_STBY, 10);
    fork
      runFrame(8'h03, 100, 1400, 16);
      begin
        #60;
        check({14'h0, powerState}, {14'h0, PS_STBY});
        measureWake(PUP_STBY_CYC);
      end
    join
    check({15'h0, convValid}, 16'h0001);
    waitState(PS_STBY, 10);
    // Auto-shutdown with reference disabled, then enabled again
    runFrame(8'h22, 5, 0, 16);
    check({14'h0, powerMode}, {14'h0, MODE_AUTO_OFF});
    check({15'h0, refDisable}, 16'h0001);
    waitState(PS_OFF, 10);
    fork
      runFrame(8'h02, 100, 1400, 16);
      measureWake(PUP_STBY_CYC);
    join
    check({15'h0, refDisable}, 16'h0000);
    waitState(PS_OFF, 10);
    fork
      runFrame(8'h00, 100, 5400, 16);
      measureWake(PUP_FULL_CYC);
    join
    check({14'h0, powerMode}, {14'h0, MODE_CS});
    waitState(PS_OFF, 10);
    repeat (10) @(negedge ref_clk);
    check(16'(expQ.size()), 16'h0000);
    results();
  end
endmodule : testbench

`default_nettype wire
